// ### hw/asf_adc_control.sv
// How it works
// - Selected pin is forced to analog input; port data/direction ignored.
// - Digital read of the converter-claimed pin returns zero.
// - High reference gives 3FF, low reference gives 000, linear between.
// - Any status/control write starts a conversion (here not one selecting channel 1F or one made in stop).
// - A conversion completes in 16 to 17 converter clocks.
// - Continuous mode overwrites results every conversion.
// - Continuous mode restarts conversions until the bit is cleared.
// - Without interrupts, completion flag sets and holds until result read.
// - Single mode does one conversion per status/control write.
// - Two-bit format field selects one of four result formats.
// - Left format: eight MSBs high, two LSBs low.
// - Interlocked formats store nothing after high read until low read.
// - Right format: two MSBs high, eight LSBs low.
// - Signed format is left format with result MSB inverted.
// - Truncation: eight MSBs in low register, two LSBs dropped.
// - Truncation format has no high/low interlock.
// - Interrupt enabled: request after each conversion, flag stays zero.
// - Converter runs in wait mode; its interrupt can wake the processor.
// - Stop aborts conversion; resume after stop with one settling cycle (here only in continuous mode).
// - Five-bit channel field: 0-7 pins, 1D high ref, 1E low ref.
// - All-ones channel field switches the converter off.
// - Interrupt clears on result read or status/control write.
// - High read freezes low register until low is read.
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module asf_adc_control
  import asf_pkg::*;
#(
  parameter int PINS = PIN_N
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic [ADDR_W-1:0]  avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  input  wire logic [PINS-1:0]    port_out_data,
  input  wire logic [PINS-1:0]    port_out_enable,
  input  wire logic [PINS-1:0]    pin_in,
  output logic [PINS-1:0]         pin_out,
  output logic [PINS-1:0]         pin_oe,
  output logic [PINS-1:0]         port_read_data,
  output logic [CH_W-1:0]         analog_mux_select,
  output logic                    analog_power_on,
  output logic                    sample_hold,
  output logic [RES_W-1:0]        dac_trial_code,
  input  wire logic               comparator_above,
  input  wire logic               stop_mode,
  output logic                    conversion_irq
);

  // ----------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------------
  logic            rst_meta_n;
  logic            rst_sync_n;
  logic [PINS-1:0] pin_meta;
  logic [PINS-1:0] pin_sync;
  logic            cmp_meta;
  logic            cmp_sync;
  logic            stop_meta;
  logic            stop_sync;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Comparator and stop come from the analog/system side, so they are synchronised too
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_meta  <= '0;
      pin_sync  <= '0;
      cmp_meta  <= 1'b0;
      cmp_sync  <= 1'b0;
      stop_meta <= 1'b0;
      stop_sync <= 1'b0;
    end else begin
      pin_meta  <= pin_in;
      pin_sync  <= pin_meta;
      cmp_meta  <= comparator_above;
      cmp_sync  <= cmp_meta;
      stop_meta <= stop_mode;
      stop_sync <= stop_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic             complete_flag;
  logic             irq_enable;
  logic             cont_bit;
  logic [CH_W-1:0]  channel;
  logic [7:0]       clock_reg;
  asf_result_t      result;
  logic             low_frozen;
  asf_state_t       state;
  asf_state_t       next_state;
  logic [4:0]       cycle_cnt;
  logic [RES_W-1:0] sar;
  logic [3:0]       bit_idx;
  logic [7:0]       div_cnt;
  logic             stop_seen;
  logic             rd_wait;

  // ----------------------------------------------------------------------
  // Bus decode; writes answer at once, reads take one wait state
  // ----------------------------------------------------------------------
  wire wr_sc    = avs_write && (avs_address == ADDR_STATUS_CONTROL);
  wire wr_clock = avs_write && (avs_address == ADDR_CLOCK);
  wire rd_sc    = avs_read  && (avs_address == ADDR_STATUS_CONTROL);
  wire rd_high  = avs_read  && (avs_address == ADDR_RESULT_HIGH);
  wire rd_low   = avs_read  && (avs_address == ADDR_RESULT_LOW);
  wire rd_clock = avs_read  && (avs_address == ADDR_CLOCK);

  // Read data come from a flop, so a read is held one cycle until they stand
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_wait <= 1'b0;
    end else begin
      rd_wait <= avs_read && !rd_wait;
    end
  end

  assign avs_waitrequest = avs_read && !rd_wait;

  asf_fmt_t fmt;
  assign fmt = asf_fmt_t'(clock_reg[CK_FMT_HI:CK_FMT_LO]);

  wire power_off = (channel == CH_POWER_OFF);
  wire pin_sel   = (channel <= CH_PIN_LAST);
  wire [2:0] pin_idx = channel[2:0];

  // ----------------------------------------------------------------------
  // Converter clock enable: divide by 2^div, source bit clear halves again
  // ----------------------------------------------------------------------
  wire [CK_DIV_W-1:0] div_sel = clock_reg[CK_DIV_LSB +: CK_DIV_W];
  wire [7:0] div_mask = (8'h01 << div_sel) - 8'h01;
  wire [7:0] div_limit = clock_reg[CK_SRC_BIT] ? div_mask : {div_mask[6:0], 1'b1};
  wire conv_tick = (div_cnt >= div_limit);

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_cnt <= 8'h00;
    end else if (conv_tick || wr_sc) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer: one settling tick, then 16 bit/latch ticks (17 total)
  // ----------------------------------------------------------------------
  wire finish = (state == ASF_CONV) && conv_tick && (cycle_cnt == CONV_CYCLES - 5'h01);
  wire halt   = stop_sync || power_off;
  // The written channel decides, else leaving power-off could never start a conversion
  wire wr_off = wr_sc && (avs_writedata[CH_W-1:0] == CH_POWER_OFF);

  always_comb begin
    next_state = state;
    case (state)
      ASF_IDLE:   next_state = state;
      ASF_SETTLE: if (conv_tick) next_state = ASF_CONV;
      ASF_CONV:   if (finish) next_state = cont_bit ? ASF_SETTLE : ASF_IDLE;
      default:    next_state = ASF_IDLE;
    endcase
    if (halt) begin
      next_state = ASF_IDLE;
    end
    if (wr_sc && !stop_sync && !wr_off) begin
      next_state = ASF_SETTLE;
    end
    if (stop_seen && !stop_sync && !power_off && cont_bit) begin
      next_state = ASF_SETTLE;
    end
  end

  wire resolving = (state == ASF_CONV) && conv_tick && (bit_idx <= BIT_TOP)
                   && (cycle_cnt != 5'h00);

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state     <= ASF_IDLE;
      cycle_cnt <= 5'h00;
      sar       <= CODE_ZERO;
      bit_idx   <= BIT_TOP;
      stop_seen <= 1'b0;
    end else begin
      state     <= next_state;
      stop_seen <= stop_sync;
      if (next_state != state || state != ASF_CONV) begin
        cycle_cnt <= 5'h01;
        sar       <= CODE_ZERO;
        bit_idx   <= BIT_TOP;
      end else if (conv_tick) begin
        cycle_cnt <= cycle_cnt + 5'h01;
        if (resolving) begin
          // Comparator says input above trial code: keep the bit
          sar[bit_idx] <= cmp_sync;
          bit_idx      <= bit_idx - 4'h1;
        end
      end
    end
  end

  wire [RES_W-1:0] trial = sar | (CODE_FULL >> (BIT_TOP - bit_idx)) & ~(CODE_FULL >> (BIT_TOP - bit_idx + 4'h1));
  assign dac_trial_code    = (state == ASF_CONV) ? trial : CODE_ZERO;
  assign sample_hold       = (state == ASF_SETTLE);
  assign analog_mux_select = channel;
  assign analog_power_on   = !power_off && !stop_sync;

  // ----------------------------------------------------------------------
  // Result formatting and interlock
  // ----------------------------------------------------------------------
  asf_result_t fmt_res;
  always_comb begin
    case (fmt)
      ASF_FMT_LEFT:   fmt_res = '{high: sar[9:2], low: {sar[1:0], 6'h00}};
      ASF_FMT_RIGHT:  fmt_res = '{high: {6'h00, sar[9:8]}, low: sar[7:0]};
      ASF_FMT_SIGNED: fmt_res = '{high: {~sar[9], sar[8:2]}, low: {sar[1:0], 6'h00}};
      ASF_FMT_TRUNC:  fmt_res = '{high: 8'h00, low: sar[9:2]};
      default:        fmt_res = '{high: 8'h00, low: 8'h00};
    endcase
  end

  wire interlocked = (fmt != ASF_FMT_TRUNC) && low_frozen;
  wire store = finish && !interlocked;

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      result     <= '{high: 8'h00, low: 8'h00};
      low_frozen <= 1'b0;
    end else begin
      if (store) begin
        result <= fmt_res;
      end
      // Freeze wins only outside truncation; a low read releases it
      if (rd_high && fmt != ASF_FMT_TRUNC) begin
        low_frozen <= 1'b1;
      end else if (rd_low) begin
        low_frozen <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control/status and clock registers
  // ----------------------------------------------------------------------
  wire result_read = rd_high || rd_low;

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_enable    <= 1'b0;
      cont_bit      <= 1'b0;
      channel       <= CH_POWER_OFF;
      clock_reg     <= CLOCK_RESET;
      complete_flag <= 1'b0;
      conversion_irq <= 1'b0;
    end else begin
      if (wr_sc) begin
        irq_enable <= avs_writedata[SC_IEN_BIT];
        cont_bit   <= avs_writedata[SC_CONT_BIT];
        channel    <= avs_writedata[CH_W-1:0];
      end
      if (wr_clock) begin
        clock_reg <= avs_writedata[7:0];
      end
      // Set wins over a same-cycle clear so no completion is lost
      if (store && !irq_enable) begin
        complete_flag <= 1'b1;
      end else if (result_read || irq_enable) begin
        complete_flag <= 1'b0;
      end
      // Runs in wait mode too; the request itself wakes the core
      if (store && irq_enable) begin
        conversion_irq <= 1'b1;
      end else if (result_read || wr_sc) begin
        conversion_irq <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Port pin override
  // ----------------------------------------------------------------------
  wire [PINS-1:0] claim = (pin_sel && !power_off) ? (PINS'(1) << pin_idx) : '0;
  assign pin_out        = port_out_data & ~claim;
  assign pin_oe         = port_out_enable & ~claim;
  assign port_read_data = pin_sync & ~claim;

  // ----------------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------------
  wire [7:0] sc_read = {complete_flag, irq_enable, cont_bit, channel};
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      avs_readdata <= 32'h00000000;
    end else begin
      avs_readdata <= 32'h00000000;
      if (rd_sc)    avs_readdata[7:0] <= sc_read;
      if (rd_high)  avs_readdata[7:0] <= result.high;
      if (rd_low)   avs_readdata[7:0] <= result.low;
      if (rd_clock) avs_readdata[7:0] <= clock_reg;
    end
  end

endmodule

// ### hw/asf_pkg.sv
package asf_pkg;

  // ----------------------------------------------------------------------
  // Register map (word-aligned byte addresses on the Avalon-MM slave)
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_RESULT_HIGH    = 4'h4;
  localparam logic [3:0] ADDR_RESULT_LOW     = 4'h8;
  localparam logic [3:0] ADDR_CLOCK          = 4'hC;
  localparam logic [3:0] ADDR_PORT_DATA      = 4'h0;
  localparam int         ADDR_W              = 4;

  // ----------------------------------------------------------------------
  // Status/control field layout
  // ----------------------------------------------------------------------
  localparam int SC_COMPLETE_BIT = 7;
  localparam int SC_IEN_BIT      = 6;
  localparam int SC_CONT_BIT     = 5;
  localparam int CH_W            = 5;
  localparam logic [4:0] CH_PIN_LAST  = 5'h07;
  localparam logic [4:0] CH_REF_HIGH  = 5'h1D;
  localparam logic [4:0] CH_REF_LOW   = 5'h1E;
  localparam logic [4:0] CH_POWER_OFF = 5'h1F;

  // ----------------------------------------------------------------------
  // Clock register field layout
  // ----------------------------------------------------------------------
  localparam int CK_DIV_LSB  = 5;
  localparam int CK_DIV_W    = 3;
  localparam int CK_SRC_BIT  = 4;
  localparam int CK_FMT_HI   = 3;
  localparam int CK_FMT_LO   = 2;
  localparam logic [7:0] CLOCK_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Conversion constants
  // ----------------------------------------------------------------------
  localparam int         RES_W      = 10;
  localparam logic [9:0] CODE_FULL  = 10'h3FF;
  localparam logic [9:0] CODE_ZERO  = 10'h000;
  localparam logic [4:0] CONV_CYCLES = 5'h11;
  localparam logic [3:0] BIT_TOP     = 4'h9;
  localparam int         PIN_N      = 8;

  typedef enum logic [1:0] {
    ASF_FMT_LEFT   = 2'h0,
    ASF_FMT_RIGHT  = 2'h1,
    ASF_FMT_SIGNED = 2'h2,
    ASF_FMT_TRUNC  = 2'h3
  } asf_fmt_t;

  typedef enum logic [2:0] {
    ASF_IDLE   = 3'b001,
    ASF_SETTLE = 3'b010,
    ASF_CONV   = 3'b100
  } asf_state_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } asf_result_t;

endpackage

// ### bench/asf_props.sv
`timescale 1ns/1ns
module asf_props
  import asf_pkg::*;
#(
  parameter int PINS = PIN_N
) (
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [31:0]       avs_readdata,
  input wire logic [PINS-1:0]   port_out_data,
  input wire logic [PINS-1:0]   port_out_enable,
  input wire logic [PINS-1:0]   pin_out,
  input wire logic [PINS-1:0]   pin_oe,
  input wire logic [PINS-1:0]   port_read_data,
  input wire logic [CH_W-1:0]   analog_mux_select,
  input wire logic              analog_power_on,
  input wire logic              stop_mode,
  input wire logic              conversion_irq
);
  // --------------------------------
  // Helpers
  // --------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic            sa = analog_mux_select <= CH_PIN_LAST;
  wire logic [PINS-1:0] m = sa ? PINS'(1) << analog_mux_select[2:0] : '0;
  wire logic            rd_hi = avs_read && avs_address == ADDR_RESULT_HIGH;
  wire logic            st_wr = avs_write && avs_address == ADDR_STATUS_CONTROL;
  logic [1:0]           f;
  // Format shadow, so result checks need no bus decode of their own
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) f <= 2'h0;
    else if (avs_write && avs_address == ADDR_CLOCK) f <= avs_writedata[3:2];
  end
  claim_oe_a: assert property (analog_power_on && sa |-> (pin_oe & m) == '0)
    else $error("claimed pin still driven");
  claim_read_a: assert property (analog_power_on && sa |-> (port_read_data & m) == '0)
    else $error("claimed pin read not zero");
  pin_pass_a: assert property ((pin_oe | m) == (port_out_enable | m) &&
    (pin_out | m) == (port_out_data | m)) else $error("free pin not under port control");
  power_off_a: assert property (analog_mux_select == CH_POWER_OFF |-> !analog_power_on)
    else $error("converter powered with channel all ones");
  stop_off_a: assert property (stop_mode [*4] |-> !analog_power_on)
    else $error("converter active in stop");
  irq_quiet_a: assert property (st_wr |=> !conversion_irq [*8])
    else $error("irq after control write");
  irq_read_a: assert property (rd_hi && conversion_irq |=> !conversion_irq)
    else $error("irq kept after result read");
  irq_flag_a: assert property (avs_read && avs_address == ADDR_STATUS_CONTROL &&
    conversion_irq |=> !avs_readdata[SC_COMPLETE_BIT]) else $error("flag set with irq");
  trunc_high_a: assert property (f == 2'h3 && rd_hi |=> avs_readdata == 32'h0)
    else $error("high register not zero in truncation");
  right_high_a: assert property (f == 2'h1 && rd_hi |=> avs_readdata[7:2] == 6'h00)
    else $error("high register upper bits set in right format");
  cover property ($rose(conversion_irq));
  cover property (stop_mode [*4]);
  cover property (f == 2'h3 && rd_hi);
endmodule
bind asf_adc_control asf_props #(.PINS(PINS)) asf_props_i (.ref_clk, .rst_n, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_readdata, .port_out_data, .port_out_enable,
  .pin_out, .pin_oe, .port_read_data, .analog_mux_select, .analog_power_on, .stop_mode,
  .conversion_irq);

// ### bench/asf_analog_model.sv
`timescale 1ns/1ns
module asf_analog_model
  import asf_pkg::*;
(
  input wire logic            ref_clk,
  input wire logic [7:0][9:0] level,
  input wire logic [7:0]      pin_out,
  input wire logic [7:0]      pin_oe,
  input wire logic [4:0]      analog_mux_select,
  input wire logic            analog_power_on,
  input wire logic [9:0]      dac_trial_code,
  output logic [7:0]          pin_in,
  output logic                comparator_above
);
  // --------------------------------
  // Pins and comparator
  // --------------------------------
  logic [9:0] vin;
  logic       tog = 1'b0;
  // A powered-down comparator gives noise, not a stale answer
  always_ff @(posedge ref_clk) tog <= ~tog;
  always_comb begin
    for (int i = 0; i < 8; i++) pin_in[i] = pin_oe[i] ? pin_out[i] : level[i][9];
    if (analog_mux_select <= CH_PIN_LAST) vin = level[analog_mux_select[2:0]];
    else if (analog_mux_select == CH_REF_HIGH) vin = CODE_FULL;
    else if (analog_mux_select == CH_REF_LOW) vin = CODE_ZERO;
    else vin = ~dac_trial_code;
    comparator_above = analog_power_on ? vin >= dac_trial_code : tog;
  end
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ns
module testbench
  import asf_pkg::*;
;
  logic            ref_clk = 1'b0;
  logic            rst_n = 1'b0;
  logic [3:0]      avs_address = 4'h0;
  logic            avs_read = 1'b0;
  logic            avs_write = 1'b0;
  logic            stop_mode = 1'b0;
  logic [31:0]     avs_writedata = 32'h0;
  logic [31:0]     avs_readdata;
  logic            avs_waitrequest, comparator_above, sample_hold, analog_power_on;
  logic            conversion_irq;
  logic [7:0]      port_out_data = 8'h00;
  logic [7:0]      port_out_enable = 8'h00;
  logic [7:0]      pin_in, pin_out, pin_oe, port_read_data, q;
  logic [4:0]      analog_mux_select;
  logic [9:0]      dac_trial_code;
  logic [7:0][9:0] level = '0;
  int              miscompares = 0;
  int              num_checks = 0;
  always #5 ref_clk = ~ref_clk;
  asf_adc_control asf_adc_control_i (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .port_out_data, .port_out_enable,
    .pin_in, .pin_out, .pin_oe, .port_read_data, .analog_mux_select, .analog_power_on,
    .sample_hold, .dac_trial_code, .comparator_above, .stop_mode, .conversion_irq);
  asf_analog_model asf_analog_model_i (.ref_clk, .level, .pin_out, .pin_oe,
    .analog_mux_select, .analog_power_on, .dac_trial_code, .pin_in, .comparator_above);
  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Read data are taken at the edge where waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h0, d};
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic waitdone(input logic ien);
    q = 8'h00;
    for (int n = 0; n < 2000; n++) begin
      if (ien ? conversion_irq === 1'b1 : q[7] === 1'b1) break;
      if (ien) @(posedge ref_clk);
      else bus(1'b0, ADDR_STATUS_CONTROL, 8'h00);
    end
  endtask
  function automatic logic [15:0] fmt(input logic [9:0] c, input logic [1:0] m);
    case (m)
      2'h0: return {c[9:2], c[1:0], 6'h00};
      2'h1: return {6'h00, c};
      2'h2: return {~c[9], c[8:2], c[1:0], 6'h00};
      default: return {8'h00, c[9:2]};
    endcase
  endfunction
  task automatic conv(input logic [4:0] ch, input logic [9:0] v, input logic [1:0] m,
    input logic ien);
    logic [15:0] e;
    if (ch <= CH_PIN_LAST) level[ch[2:0]] <= v;
    e = fmt(ch == CH_REF_HIGH ? CODE_FULL : ch == CH_REF_LOW ? CODE_ZERO : v, m);
    bus(1'b1, ADDR_CLOCK, {3'h6, 1'b1, m, 2'h0});
    bus(1'b1, ADDR_STATUS_CONTROL, {1'b0, ien, 1'b0, ch});
    waitdone(ien);
    bus(1'b0, ADDR_STATUS_CONTROL, 8'h00);
    chk({7'h0, q[7]}, {7'h0, ~ien});
    bus(1'b0, ADDR_RESULT_HIGH, 8'h00);
    chk(q, e[15:8]);
    chk({7'h0, conversion_irq}, 8'h00);
    bus(1'b0, ADDR_RESULT_LOW, 8'h00);
    chk(q, e[7:0]);
  endtask
  // --------------------------------
  // Sequence
  // --------------------------------
  initial begin
    repeat (60000) @(posedge ref_clk);
    miscompares++;
    close_out();
  end
  initial begin
    void'($urandom(32'h6AB0));
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    bus(1'b0, ADDR_STATUS_CONTROL, 8'h00);
    chk(q, 8'h1F);
    chk({7'h0, analog_power_on}, 8'h00);
    for (int i = 0; i < 8; i++) conv(5'($urandom_range(7)), 10'($urandom), 2'(i), i[2]);
    conv(CH_REF_HIGH, 10'h000, 2'h1, 1'b0);
    conv(CH_REF_LOW, 10'h000, 2'h1, 1'b0);
    conv(5'h07, 10'h200, 2'h2, 1'b0);
    port_out_enable <= 8'hFF;
    port_out_data <= 8'($urandom);
    repeat (4) @(posedge ref_clk);
    chk(pin_oe, 8'h7F);
    chk(pin_out, port_out_data & 8'h7F);
    chk(port_read_data, port_out_data & 8'h7F);
    conv(5'h02, 10'h155, 2'h0, 1'b0);
    level[2] <= 10'h2AA;
    bus(1'b0, ADDR_RESULT_HIGH, 8'h00);
    bus(1'b1, ADDR_STATUS_CONTROL, 8'h02);
    repeat (1300) @(posedge ref_clk);
    bus(1'b0, ADDR_RESULT_LOW, 8'h00);
    chk(q, 8'h40);
    bus(1'b0, ADDR_RESULT_HIGH, 8'h00);
    chk(q, 8'h55);
    conv(5'h02, 10'h2AA, 2'h3, 1'b0);
    bus(1'b0, ADDR_RESULT_HIGH, 8'h00);
    level[2] <= 10'h0F0;
    bus(1'b1, ADDR_STATUS_CONTROL, 8'h02);
    waitdone(1'b0);
    bus(1'b0, ADDR_RESULT_LOW, 8'h00);
    chk(q, 8'h3C);
    bus(1'b1, ADDR_STATUS_CONTROL, 8'h22);
    waitdone(1'b0);
    level[2] <= 10'h3C0;
    repeat (2600) @(posedge ref_clk);
    bus(1'b0, ADDR_RESULT_LOW, 8'h00);
    chk(q, 8'hF0);
    // The write lands mid-conversion; only the next finished result is used
    bus(1'b1, ADDR_STATUS_CONTROL, 8'h02);
    bus(1'b0, ADDR_RESULT_LOW, 8'h00);
    waitdone(1'b0);
    bus(1'b0, ADDR_RESULT_LOW, 8'h00);
    repeat (2400) @(posedge ref_clk);
    bus(1'b0, ADDR_STATUS_CONTROL, 8'h00);
    chk({7'h0, q[7]}, 8'h00);
    bus(1'b1, ADDR_STATUS_CONTROL, 8'h02);
    repeat (300) @(posedge ref_clk);
    stop_mode <= 1'b1;
    repeat (1500) @(posedge ref_clk);
    chk({7'h0, analog_power_on}, 8'h00);
    bus(1'b0, ADDR_STATUS_CONTROL, 8'h00);
    chk({7'h0, q[7]}, 8'h00);
    stop_mode <= 1'b0;
    bus(1'b1, ADDR_STATUS_CONTROL, 8'h1F);
    repeat (2) @(posedge ref_clk);
    chk({7'h0, analog_power_on}, 8'h00);
    close_out();
  end
endmodule
